// File: src/fbgp_cfg.svh
// offsets, field positions and reset values for the five-pin port
`ifndef FBGP_CFG_SVH
`define FBGP_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------------------
`define FBGP_OFS_LEVEL     4'h0
`define FBGP_OFS_DIR       4'h1
`define FBGP_OFS_LATCH     4'h2
`define FBGP_OFS_CONV1     4'h3
`define FBGP_OFS_CMPCTL    4'h4

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define FBGP_CONV_CFG_LSB  0
`define FBGP_CONV_CFG_W    4
`define FBGP_CMP_MODE_LSB  0
`define FBGP_CMP_MODE_W    3
`define FBGP_CMP_C2OE_BIT  3
`define FBGP_CMP_C2RES_BIT 7
`define FBGP_PIN_ZERO      0
`define FBGP_PIN_THREE     3
`define FBGP_PIN_FIVE      5

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define FBGP_RST_DIR       8'h3f
`define FBGP_RST_LATCH     8'h00
`define FBGP_RST_CONV1     8'h00
`define FBGP_RST_CMPCTL    8'h07
`define FBGP_CMP_OFF       3'h7
`define FBGP_USED_MASK     8'h2f

`endif

// File: src/fbgp_pkg.sv
// types shared by the five-pin port files
package fbgp_pkg;
    typedef logic [7:0] fbgp_byte_t;
    typedef enum logic [1:0] {
        FBGP_PIN_DIGITAL,
        FBGP_PIN_ANALOG,
        FBGP_PIN_CMP_OUT
    } fbgp_pin_mode_e;
endpackage : fbgp_pkg

// File: src/fbgp_pin_sync.sv
// two-flop synchroniser for the pin inputs
module fbgp_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk_in,  // system clock
    input  wire logic             rstn_in,  // async reset, active low
    input  wire logic             ce_in,    // clock enable
    input  wire logic [WIDTH-1:0] d_in,     // asynchronous pin levels
    output logic      [WIDTH-1:0] q_out     // synchronised levels
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else if (ce_in) begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule : fbgp_pin_sync

// File: src/fbgp_port.sv
// five-pin bidirectional general purpose port with analog and comparator muxing
`include "fbgp_cfg.svh"

module fbgp_port
    import fbgp_pkg::*;
(
    input  wire logic       mclk_in,       // system clock, 125 MHz
    input  wire logic       rstn_in,       // async reset, active low
    input  wire logic       ce_in,         // clock enable, freezes state when low
    input  wire logic [3:0] addr_in,       // register address
    input  wire logic [7:0] wdata_in,      // register write data
    input  wire logic       wr_in,         // write strobe
    input  wire logic       rd_in,         // read strobe
    output logic      [7:0] rdata_out,     // read data, valid cycle after rd_in
    input  wire logic [7:0] pin_in,        // pad levels, bits 3:0 and 5 used
    output logic      [7:0] pin_out,       // pad output values
    output logic      [7:0] pin_oe_out,    // pad output enables, high drives
    input  wire logic       cmp2_res_in,   // second comparator result, same clock
    output logic      [7:0] analog_en_out  // analog input selected per pin
);
    fbgp_byte_t dir_q;
    fbgp_byte_t latch_q;
    fbgp_byte_t conv1_q;
    fbgp_byte_t cmpctl_q;
    fbgp_byte_t pin_sync;
    fbgp_byte_t analog_sel;
    fbgp_byte_t dig_in;
    fbgp_byte_t rd_d;
    fbgp_pin_mode_e pin_mode [8];
    logic       cmp_off;
    logic       c2_oe;

    // ------------------------------------------------------------------------
    // pad input synchroniser
    // ------------------------------------------------------------------------
    fbgp_pin_sync #(.WIDTH(8)) u_sync (
        .mclk_in (mclk_in),
        .rstn_in (rstn_in),
        .ce_in   (ce_in),
        .d_in    (pin_in),
        .q_out   (pin_sync)
    );

    // ------------------------------------------------------------------------
    // analog selection decode
    // ------------------------------------------------------------------------
    // each pin goes analog below its own code, pin 0 below 4'hf up to pin 5 below 4'hb; reset code 0 makes all analog
    function automatic fbgp_byte_t analog_map(input logic [3:0] cfg);
        fbgp_byte_t m;
        m = 8'h00;
        if (cfg < 4'hf) m[0] = 1'b1;
        if (cfg < 4'he) m[1] = 1'b1;
        if (cfg < 4'hd) m[2] = 1'b1;
        if (cfg < 4'hc) m[3] = 1'b1;
        if (cfg < 4'hb) m[5] = 1'b1;
        return m;
    endfunction : analog_map

    // pins 4, 6 and 7 are absent, so their input and driver paths stay tied off
    function automatic logic pin_used(input int idx);
        fbgp_byte_t mask;
        mask = `FBGP_USED_MASK;
        return mask[idx[2:0]];
    endfunction : pin_used

    assign cmp_off = (cmpctl_q[`FBGP_CMP_MODE_LSB +: `FBGP_CMP_MODE_W] == `FBGP_CMP_OFF);
    assign c2_oe   = cmpctl_q[`FBGP_CMP_C2OE_BIT];

    always_comb begin
        analog_sel = analog_map(conv1_q[`FBGP_CONV_CFG_LSB +: `FBGP_CONV_CFG_W]);
        // comparators claim pins zero and three as analog inputs
        if (!cmp_off) begin
            analog_sel[`FBGP_PIN_ZERO]  = 1'b1;
            analog_sel[`FBGP_PIN_THREE] = 1'b1;
        end
        analog_sel = analog_sel & `FBGP_USED_MASK;
    end

    // ------------------------------------------------------------------------
    // per-pin mode and digital input path
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            always_comb begin
                if (gi == `FBGP_PIN_FIVE && c2_oe)
                    pin_mode[gi] = FBGP_PIN_CMP_OUT;
                else if (analog_sel[gi])
                    pin_mode[gi] = FBGP_PIN_ANALOG;
                else
                    pin_mode[gi] = FBGP_PIN_DIGITAL;
            end
            // analog pins read zero; unused pins read zero
            assign dig_in[gi] = pin_used(gi) & !analog_sel[gi] & pin_sync[gi];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dir_q <= `FBGP_RST_DIR;
        end else if (ce_in && wr_in && addr_in == `FBGP_OFS_DIR) begin
            dir_q <= wdata_in & `FBGP_USED_MASK;
        end
    end

    // both the level and the latch offsets store into the one latch
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            latch_q <= `FBGP_RST_LATCH;
        end else if (ce_in && wr_in && (addr_in == `FBGP_OFS_LEVEL || addr_in == `FBGP_OFS_LATCH)) begin
            latch_q <= wdata_in & `FBGP_USED_MASK;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            conv1_q <= `FBGP_RST_CONV1;
        end else if (ce_in && wr_in && addr_in == `FBGP_OFS_CONV1) begin
            conv1_q <= {4'h0, wdata_in[3:0]};
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmpctl_q <= `FBGP_RST_CMPCTL;
        end else if (ce_in && wr_in && addr_in == `FBGP_OFS_CMPCTL) begin
            cmpctl_q <= {4'h0, wdata_in[3:0]};
        end
    end

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    always_comb begin
        case (addr_in)
            `FBGP_OFS_LEVEL:  rd_d = dig_in;
            `FBGP_OFS_DIR:    rd_d = dir_q;
            `FBGP_OFS_LATCH:  rd_d = latch_q;
            `FBGP_OFS_CONV1:  rd_d = conv1_q;
            `FBGP_OFS_CMPCTL: rd_d = {cmp2_res_in, 3'h0, cmpctl_q[3:0]};
            default:          rd_d = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            rdata_out <= rd_in ? rd_d : 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // pad drivers
    // ------------------------------------------------------------------------
    // direction gates the driver even on analog pins, so software must keep it set
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_oe_out <= 8'h00;
        end else if (ce_in) begin
            for (int i = 0; i < 8; i++) begin
                if (pin_mode[i] == FBGP_PIN_CMP_OUT)
                    pin_oe_out[i] <= 1'b1;
                else
                    pin_oe_out[i] <= pin_used(i) & !dir_q[i];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_out <= 8'h00;
        end else if (ce_in) begin
            pin_out <= latch_q;
            if (c2_oe)
                pin_out[`FBGP_PIN_FIVE] <= cmp2_res_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            analog_en_out <= `FBGP_USED_MASK;
        end else if (ce_in) begin
            analog_en_out <= analog_sel;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    property p_drive_latch;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && !c2_oe ##1 ce_in |-> pin_out[1] == $past(latch_q[1]);
    endproperty
    a_drive_latch: assert property (p_drive_latch) else $error("pin one does not follow latch");

    property p_dir_release;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && dir_q[2] |=> !pin_oe_out[2];
    endproperty
    a_dir_release: assert property (p_dir_release) else $error("input pin still driven");

    property p_level_write;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && wr_in && addr_in == `FBGP_OFS_LEVEL |=> latch_q == ($past(wdata_in) & `FBGP_USED_MASK);
    endproperty
    a_level_write: assert property (p_level_write) else $error("level write missed latch");

    property p_latch_read;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && rd_in && addr_in == `FBGP_OFS_LATCH |=> rdata_out == $past(latch_q);
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

    property p_analog_zero;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && rd_in && addr_in == `FBGP_OFS_LEVEL && analog_sel[3] |=> !rdata_out[3];
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

    property p_cmp_override;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && c2_oe |=> pin_oe_out[5] && pin_out[5] == $past(cmp2_res_in);
    endproperty
    a_cmp_override: assert property (p_cmp_override) else $error("comparator not on pin five");

    property p_cmp_claims;
        @(posedge mclk_in) disable iff (!rstn_in)
        !cmp_off |-> analog_sel[0] && analog_sel[3];
    endproperty
    a_cmp_claims: assert property (p_cmp_claims) else $error("comparator pins left digital");

    property p_conv_map;
        @(posedge mclk_in) disable iff (!rstn_in)
        conv1_q[3:0] == 4'h0 |-> analog_sel == `FBGP_USED_MASK;
    endproperty
    a_conv_map: assert property (p_conv_map) else $error("config zero not all analog");

    property p_unused_quiet;
        @(posedge mclk_in) disable iff (!rstn_in)
        pin_oe_out[4] == 1'b0 && pin_oe_out[7:6] == 2'b00;
    endproperty
    a_unused_quiet: assert property (p_unused_quiet) else $error("unused pin driven");

    property p_analog_drive;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && analog_sel[1] && !dir_q[1] |=> pin_oe_out[1];
    endproperty
    a_analog_drive: assert property (p_analog_drive) else $error("analog pin driver lost");

    property p_latch_write;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && wr_in && addr_in == `FBGP_OFS_LATCH |=> latch_q == ($past(wdata_in) & `FBGP_USED_MASK);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write missed latch");

    property p_read_idle;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && !rd_in |=> rdata_out == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read cycle");

    property p_level_read;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && rd_in && addr_in == `FBGP_OFS_LEVEL && !analog_sel[1] |=> rdata_out[1] == $past(pin_sync[1]);
    endproperty
    a_level_read: assert property (p_level_read) else $error("digital pin level not read");

    property p_unused_read;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && rd_in && addr_in == `FBGP_OFS_LEVEL |=> rdata_out[4] == 1'b0 && rdata_out[7:6] == 2'b00;
    endproperty
    a_unused_read: assert property (p_unused_read) else $error("absent pin read nonzero");

    property p_cmp_off_digital;
        @(posedge mclk_in) disable iff (!rstn_in)
        ce_in && cmp_off && conv1_q[3:0] == 4'hf |=> analog_en_out == 8'h00;
    endproperty
    a_cmp_off_digital: assert property (p_cmp_off_digital) else $error("digital setup left analog pins");

    property p_ce_freeze;
        @(posedge mclk_in) disable iff (!rstn_in)
        !ce_in |=> $stable(latch_q) && $stable(dir_q) && $stable(rdata_out);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

    c_level_read: cover property (@(posedge mclk_in) disable iff (!rstn_in) rd_in && addr_in == `FBGP_OFS_LEVEL);
    c_cmp_out:    cover property (@(posedge mclk_in) disable iff (!rstn_in) c2_oe && pin_oe_out[5]);
    c_all_dig:    cover property (@(posedge mclk_in) disable iff (!rstn_in) analog_sel == 8'h00);
    c_drive_low:  cover property (@(posedge mclk_in) disable iff (!rstn_in) pin_oe_out[0] && !pin_out[0]);
endmodule : fbgp_port

// File: dv/fbgp_ext_circuit.sv
// far-side model: external circuits with pull-ups on the port pins
module fbgp_ext_circuit (
    input  wire logic [7:0] drv_in,     // values driven by the port
    input  wire logic [7:0] oe_in,      // port output enables
    input  wire logic [7:0] ext_oe_in,  // external driver enables
    input  wire logic [7:0] ext_val_in, // external driver values
    output logic      [7:0] level_out   // resolved pad levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------------
    // pad resolution
    // --------------------------------------------------------------------
    // released lines float to the pull-up so a cleared latch plus direction toggling signals both levels
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level_out[i] = oe_in[i] ? drv_in[i] : (ext_oe_in[i] ? ext_val_in[i] : 1'b1);
        end
    end
endmodule : fbgp_ext_circuit

// File: dv/test_five_bit_gpio_port.sv
// self-checking bench for the five-pin port
`include "fbgp_cfg.svh"
module test_five_bit_gpio_port import fbgp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0;
    logic       rstn = 1'b0;
    logic       ce = 1'b1;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       cmp2 = 1'b0;
    logic       rd_seen = 1'b0;
    logic [3:0] addr = 4'h0;
    fbgp_byte_t wdata = 8'h00;
    fbgp_byte_t ext_oe = 8'h00;
    fbgp_byte_t ext_val = 8'h00;
    fbgp_byte_t rdata, pin_lvl, pin_o, pin_oe, aen, v, m;
    fbgp_byte_t expq[$];
    int         n_fail = 0;
    int         n_compared = 0;
    int         cyc = 0;
    int         seed = 93058;

    fbgp_port dut_u (.mclk_in(mclk), .rstn_in(rstn), .ce_in(ce), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .pin_in(pin_lvl), .pin_out(pin_o),
        .pin_oe_out(pin_oe), .cmp2_res_in(cmp2), .analog_en_out(aen));
    fbgp_ext_circuit ext_u (.drv_in(pin_o), .oe_in(pin_oe), .ext_oe_in(ext_oe), .ext_val_in(ext_val),
        .level_out(pin_lvl));

    initial begin
        forever #4 mclk = ~mclk;
    end

    // --------------------------------------------------------------------
    // checking and bus tasks
    // --------------------------------------------------------------------
    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input fbgp_byte_t seen, input fbgp_byte_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // strobes are not lowered here so back-to-back calls never assign twice in one step
    task automatic wr_reg(input logic [3:0] a, input fbgp_byte_t d);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, input fbgp_byte_t exp);
        rd <= 1'b1;
        wr <= 1'b0;
        addr <= a;
        expq.push_back(exp);
        @(posedge mclk);
    endtask : rd_reg

    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask : idle

    // read data stand only in the cycle after the strobe, so look mid-cycle
    always @(posedge mclk) rd_seen <= rd & rstn;
    always @(negedge mclk) begin
        if (rd_seen && expq.size() > 0) begin
            check(rdata, expq.pop_front());
        end
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc > 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // --------------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        idle(2);
        check(aen, 8'h2f);
        check(pin_oe, 8'h00);
        rd_reg(`FBGP_OFS_LEVEL, 8'h00);
        rd_reg(`FBGP_OFS_DIR, `FBGP_RST_DIR);
        rd_reg(`FBGP_OFS_LATCH, `FBGP_RST_LATCH);
        rd_reg(`FBGP_OFS_CONV1, `FBGP_RST_CONV1);
        rd_reg(`FBGP_OFS_CMPCTL, `FBGP_RST_CMPCTL);
        rd_reg(4'hf, 8'h00);
        wr_reg(`FBGP_OFS_CONV1, 8'h0f);
        wr_reg(`FBGP_OFS_CMPCTL, 8'h07);
        idle(3);
        check(aen, 8'h00);
        for (int k = 0; k < 4; k++) begin
            v = 8'($random(seed));
            wr_reg(`FBGP_OFS_LEVEL, v);
            rd_reg(`FBGP_OFS_LATCH, v & 8'h2f);
            wr_reg(`FBGP_OFS_LATCH, ~v);
            rd_reg(`FBGP_OFS_LATCH, ~v & 8'h2f);
            wr_reg(`FBGP_OFS_DIR, 8'h00);
            idle(4);
            check(pin_oe, 8'h2f);
            check(pin_o & 8'h2f, ~v & 8'h2f);
            rd_reg(`FBGP_OFS_LEVEL, ~v & 8'h2f);
            wr_reg(`FBGP_OFS_DIR, 8'hff);
            ext_oe <= 8'hff;
            ext_val <= v;
            idle(4);
            check(pin_oe, 8'h00);
            rd_reg(`FBGP_OFS_LEVEL, v & 8'h2f);
            rd_reg(`FBGP_OFS_DIR, 8'h2f);
            ext_oe <= 8'h00;
        end
        wr_reg(`FBGP_OFS_LATCH, 8'h00);
        idle(4);
        rd_reg(`FBGP_OFS_LEVEL, 8'h2f);
        wr_reg(`FBGP_OFS_DIR, 8'h2e);
        idle(4);
        rd_reg(`FBGP_OFS_LEVEL, 8'h2e);
        wr_reg(`FBGP_OFS_DIR, 8'hff);
        for (int c = 0; c < 16; c++) begin
            m = {2'b00, c < 11, 1'b0, c < 12, c < 13, c < 14, c < 15};
            wr_reg(`FBGP_OFS_CONV1, 8'(c));
            idle(4);
            check(aen, m);
            rd_reg(`FBGP_OFS_LEVEL, 8'h2f & ~m);
        end
        v = 8'($random(seed));
        wr_reg(`FBGP_OFS_CONV1, 8'h00);
        wr_reg(`FBGP_OFS_LATCH, v);
        wr_reg(`FBGP_OFS_DIR, 8'h00);
        idle(4);
        check(pin_oe, 8'h2f);
        check(pin_o & 8'h2f, v & 8'h2f);
        rd_reg(`FBGP_OFS_LEVEL, 8'h00);
        wr_reg(`FBGP_OFS_CONV1, 8'h0f);
        wr_reg(`FBGP_OFS_DIR, 8'hff);
        wr_reg(`FBGP_OFS_CMPCTL, 8'h02);
        idle(4);
        check(aen, 8'h09);
        wr_reg(`FBGP_OFS_CMPCTL, 8'h0f);
        wr_reg(`FBGP_OFS_LATCH, 8'h20);
        for (int k = 0; k < 6; k++) begin
            cmp2 <= 1'($random(seed));
            idle(4);
            check(aen, 8'h00);
            check(pin_oe, 8'h20);
            check({7'h00, pin_o[5]}, {7'h00, cmp2});
            rd_reg(`FBGP_OFS_CMPCTL, {cmp2, 7'h0f});
        end
        // with the enable low a write must not land
        ce <= 1'b0;
        wr_reg(`FBGP_OFS_LATCH, 8'h0f);
        ce <= 1'b1;
        rd_reg(`FBGP_OFS_LATCH, 8'h20);
        idle(3);
        tally_and_finish();
    end
endmodule : test_five_bit_gpio_port
